/* File: design/opcode_field_cfg.svh */
// Encodings and field positions for the instruction field decoder
// Function
// [RULE1] Scale code 00..11 multiplies index by 1, 2, 4 or 8.
// [RULE2] Index code picks a general register; code 100 means no index.
// [RULE3] Software encodes scale 00 when index is 100, else address undefined.
// [RULE4] Direction 0: reg is source; 1: reg is destination.
// [RULE5] Sign-extend bit widens only an 8-bit immediate to 16 or 32 bits.
// [RULE6] Upper three condition bits choose the test; lowest bit negates it.
// [RULE7] Condition codes: overflow, below, zero, below-equal, sign, parity, less, less-equal.
// [RULE8] Control register codes 000, 010, 011 only; others prohibited.
// [RULE9] Debug codes 000-011 breakpoints, 110 status, 111 control; others prohibited.
// [RULE10] Test codes 011-111 select test registers 3-7; lower codes prohibited.
// [RULE11] First byte upper bits 11011 marks floating point, at least two bytes.
// [RULE12] Memory format field picks real32, int32, real64 or int16; opcode split.
// [RULE13] Pop bit 1 pops stack after the operation; 0 leaves it.
// [RULE14] Destination bit picks top or element i; reverse xor destination orders operands.
// [RULE15] Stack element field addresses entries relative to top, 000 is top.
// [RULE16] Floating point mod and r/m follow integer rules for index byte and displacement.
// [RULE17] Prohibited special-register codes flag illegal and never reach a register access.
`ifndef OPCODE_FIELD_CFG_SVH
`define OPCODE_FIELD_CFG_SVH
`define FP_ESCAPE_PATTERN   5'h1B
`define FP_MIN_LENGTH       3'h2
`define SIB_NO_INDEX        3'h4
`define SIB_SCALE_ONE       2'h0
`define RM_SIB_PRESENT      3'h4
`define RM_DISP32_ONLY      3'h5
`define MOD_REGISTER        2'h3
`define MOD_DISP8           2'h1
`define MOD_DISP32          2'h2
`define MOD_NO_DISP         2'h0
`define BASE_DISP32_ONLY    3'h5
`define SPECIAL_CONTROL     2'h0
`define SPECIAL_DEBUG       2'h1
`define SPECIAL_TEST        2'h2
`define TEST_LOWEST_CODE    3'h3
`endif

/* File: design/opcode_field_decoder.sv */
// Registered instruction field decoder for integer and floating point fields
`include "opcode_field_cfg.svh"
`default_nettype none
module opcode_field_decoder (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	// Fetch side
	input  wire logic                            instValid,
	input  wire opcode_field_pkg::inst_bytes_s   instBytes,
	input  wire logic                            immIsByte,
	input  wire logic [31:0]                     immRaw,
	input  wire logic                            destWide32,
	input  wire logic [1:0]                      specialClass,
	input  wire opcode_field_pkg::flags_s        flags,
	// Address generation side
	output logic                                 decValid_q,
	output opcode_field_pkg::addr_fields_s       addrFields_q,
	output logic                                 undefinedAddr_q,
	// Execution side
	output logic [2:0]                           srcReg_q,
	output logic                                 srcIsRm_q,
	output logic                                 dstIsRm_q,
	output logic [31:0]                          immValue_q,
	output opcode_field_pkg::cond_e              condSel_q,
	output logic                                 condNegate_q,
	output logic                                 condTaken_q,
	output logic                                 specialLegal_q,
	output logic [2:0]                           specialIndex_q,
	output logic                                 illegalInst_q,
	output opcode_field_pkg::fp_fields_s         fpFields_q
);
	logic [7:0]                     firstByte;
	logic [7:0]                     modRm;
	logic                           dirBit;
	logic                           signExt;
	logic [3:0]                     condField;
	logic                           condRaw;
	logic                           condTaken_d;
	logic                           isFloat;
	logic                           specialLegal;
	logic [2:0]                     specialIndex;
	logic [31:0]                    immValue_d;
	opcode_field_pkg::addr_fields_s addrFields;
	opcode_field_pkg::fp_fields_s   fpFields_d;

	assign firstByte = instBytes.first;
	assign modRm     = instBytes.second;
	assign dirBit    = firstByte[1];
	assign signExt   = firstByte[1];
	assign condField = firstByte[3:0];

	// Same address decode serves integer and floating point forms [RULE16]
	sib_field_decode u_sib_field_decode (
		.modRm  (modRm),
		.sib    (instBytes.sib),
		.fields (addrFields)
	);

	special_reg_decode u_special_reg_decode (
		.regClass (specialClass),
		.regCode  (modRm[5:3]),
		.legal    (specialLegal),
		.regIndex (specialIndex)
	);

	// Condition test
	always_comb begin
		case (opcode_field_pkg::cond_e'(condField[3:1])) // [RULE7]
			opcode_field_pkg::COND_OVERFLOW: condRaw = flags.overflow;
			opcode_field_pkg::COND_BELOW:    condRaw = flags.carry;
			opcode_field_pkg::COND_ZERO:     condRaw = flags.zero;
			opcode_field_pkg::COND_BELOW_EQ: condRaw = flags.carry | flags.zero;
			opcode_field_pkg::COND_SIGN:     condRaw = flags.sign;
			opcode_field_pkg::COND_PARITY:   condRaw = flags.parity;
			opcode_field_pkg::COND_LESS:     condRaw = flags.sign ^ flags.overflow;
			opcode_field_pkg::COND_LESS_EQ:  condRaw = (flags.sign ^ flags.overflow) | flags.zero;
			default:                         condRaw = 1'b0;
		endcase
		condTaken_d = condRaw ^ condField[0]; // [RULE6]
	end

	// Immediate widening; a word or dword immediate passes untouched
	always_comb begin
		immValue_d = immRaw;
		if (immIsByte) begin
			if (signExt) begin
				immValue_d = destWide32 ? {{24{immRaw[7]}}, immRaw[7:0]} // [RULE5]
					: {16'h0000, {8{immRaw[7]}}, immRaw[7:0]};
			end else begin
				immValue_d = {24'h000000, immRaw[7:0]};
			end
		end
	end

	// Floating point escape fields
	assign isFloat = (firstByte[7:3] == `FP_ESCAPE_PATTERN); // [RULE11]
	always_comb begin
		fpFields_d = '0;
		fpFields_d.isFloat = isFloat;
		fpFields_d.minLength = isFloat ? `FP_MIN_LENGTH : 3'h1; // [RULE11]
		fpFields_d.opcodePartA = {firstByte[2:1], firstByte[0]};
		fpFields_d.opcodePartB = modRm[5:3];
		if (isFloat) begin
			// Memory forms carry the format field [RULE12]
			fpFields_d.memFormatValid = !addrFields.registerOperand;
			fpFields_d.memFormat = opcode_field_pkg::mem_format_e'(firstByte[2:1]);
			fpFields_d.popStack = addrFields.registerOperand & firstByte[1]; // [RULE13]
			fpFields_d.destIsElement = addrFields.registerOperand & firstByte[2]; // [RULE14]
			fpFields_d.reverseOrder = modRm[3] ^ firstByte[2]; // [RULE14]
			fpFields_d.stackElement = modRm[2:0]; // [RULE15]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			decValid_q <= 1'b0;
		end else begin
			decValid_q <= instValid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addrFields_q <= '0;
			undefinedAddr_q <= 1'b0;
		end else if (instValid) begin
			addrFields_q <= addrFields;
			// Flagged only; software must avoid it [RULE3]
			undefinedAddr_q <= addrFields.sibPresent && (instBytes.sib[5:3] == `SIB_NO_INDEX)
				&& (instBytes.sib[7:6] != `SIB_SCALE_ONE);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srcReg_q <= 3'h0;
			srcIsRm_q <= 1'b0;
			dstIsRm_q <= 1'b0;
		end else if (instValid) begin
			srcIsRm_q <= dirBit; // [RULE4]
			dstIsRm_q <= !dirBit; // [RULE4]
			srcReg_q <= dirBit ? modRm[2:0] : modRm[5:3];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			immValue_q <= 32'h00000000;
		end else if (instValid) begin
			immValue_q <= immValue_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			condSel_q <= opcode_field_pkg::COND_OVERFLOW;
			condNegate_q <= 1'b0;
			condTaken_q <= 1'b0;
		end else if (instValid) begin
			condSel_q <= opcode_field_pkg::cond_e'(condField[3:1]);
			condNegate_q <= condField[0];
			condTaken_q <= condTaken_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			specialLegal_q <= 1'b0;
			specialIndex_q <= 3'h0;
			illegalInst_q <= 1'b0;
		end else if (instValid) begin
			specialLegal_q <= specialLegal;
			specialIndex_q <= specialIndex;
			// No special access means nothing to refuse [RULE17]
			illegalInst_q <= (specialClass != 2'h3) && !specialLegal;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fpFields_q <= '0;
		end else if (instValid) begin
			fpFields_q <= fpFields_d;
		end
	end

	// Checks on the registered decode
	scale_factor_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
		instValid |=> addrFields_q.scaleFactor == 4'(4'h1 << $past(instBytes.sib[7:6])))
		else $error("Scale factor wrong");
	no_index_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
		instValid && instBytes.sib[5:3] == 3'h4 |=> !addrFields_q.indexValid)
		else $error("Index used for code 100");
	direction_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		instValid |=> srcIsRm_q == $past(firstByte[1]) && dstIsRm_q != srcIsRm_q)
		else $error("Direction wrong");
	sign_ext_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		instValid && immIsByte && signExt && destWide32 |=> immValue_q[31:8] == {24{immValue_q[7]}})
		else $error("Sign extension wrong");
	cond_negate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
		instValid |=> condTaken_q == ($past(condRaw) ^ condNegate_q))
		else $error("Condition negation wrong");
	control_code_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
		instValid && specialClass == 2'h0 && modRm[5:3] == 3'h1 |=> illegalInst_q && !specialLegal_q)
		else $error("Control code 001 accepted");
	debug_code_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
		instValid && specialClass == 2'h1 |=> specialLegal_q == ($past(modRm[5:3]) != 3'h4 && $past(modRm[5:3]) != 3'h5))
		else $error("Debug code decode wrong");
	test_code_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
		instValid && specialClass == 2'h2 |=> specialLegal_q == ($past(modRm[5:3]) >= 3'h3))
		else $error("Test code decode wrong");
	illegal_blocked_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
		!specialLegal_q |-> specialIndex_q == 3'h0)
		else $error("Prohibited code forwarded");
	float_detect_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		instValid |=> fpFields_q.isFloat == ($past(firstByte[7:3]) == 5'h1B)
			&& (!fpFields_q.isFloat || fpFields_q.minLength == 3'h2))
		else $error("Float escape decode wrong");

	// Decode walk: bytes taken at an edge, fields shown after it
	sequence offerSeq;
		instValid;
	endsequence
	sequence idleSeq;
		!instValid;
	endsequence
	sequence regFloatSeq;
		instValid && isFloat && addrFields.registerOperand;
	endsequence
	sequence memFloatSeq;
		instValid && isFloat && !addrFields.registerOperand;
	endsequence

	valid_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
		offerSeq |=> decValid_q)
		else $error("Decode valid missing");
	valid_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		idleSeq |=> !decValid_q)
		else $error("Decode valid without offer");
	fields_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		idleSeq |=> $stable(addrFields_q) && $stable(fpFields_q)
			&& $stable(immValue_q) && $stable(condTaken_q) && $stable(specialIndex_q))
		else $error("Fields changed while idle");
	undefined_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
		offerSeq |=> undefinedAddr_q == ($past(addrFields.sibPresent)
			&& $past(instBytes.sib[5:3]) == 3'h4 && $past(instBytes.sib[7:6]) != 2'h0))
		else $error("Undefined address flag wrong");
	index_select_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
		instValid && addrFields.sibPresent && instBytes.sib[5:3] != 3'h4
			|=> addrFields_q.indexValid && addrFields_q.indexReg == $past(instBytes.sib[5:3]))
		else $error("Index register wrong");
	src_reg_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
		offerSeq |=> srcReg_q == ($past(dirBit) ? $past(modRm[2:0]) : $past(modRm[5:3])))
		else $error("Source register wrong");
	zero_ext_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		instValid && immIsByte && !signExt |=> immValue_q[31:8] == 24'h000000)
		else $error("Byte immediate not zero filled");
	imm_pass_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		instValid && !immIsByte |=> immValue_q == $past(immRaw))
		else $error("Wide immediate altered");
	sign_ext16_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
		instValid && immIsByte && signExt && !destWide32
			|=> immValue_q[15:8] == {8{immValue_q[7]}} && immValue_q[31:16] == 16'h0000)
		else $error("Word sign extension wrong");
	cond_below_eq_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		instValid && condField[3:1] == 3'h3
			|=> condTaken_q == (($past(flags.carry) | $past(flags.zero)) ^ condNegate_q))
		else $error("Below or equal test wrong");
	cond_less_eq_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		instValid && condField[3:1] == 3'h7
			|=> condTaken_q == ((($past(flags.sign) ^ $past(flags.overflow))
				| $past(flags.zero)) ^ condNegate_q))
		else $error("Less or equal test wrong");
	cond_sign_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		instValid && condField[3:1] == 3'h4 |=> condTaken_q == ($past(flags.sign) ^ condNegate_q))
		else $error("Sign test wrong");
	cond_parity_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
		instValid && condField[3:1] == 3'h5 |=> condTaken_q == ($past(flags.parity) ^ condNegate_q))
		else $error("Parity test wrong");
	not_float_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
		instValid && !isFloat |=> !fpFields_q.isFloat && fpFields_q.minLength == 3'h1)
		else $error("Integer opcode taken as float");
	mem_format_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
		memFloatSeq |=> fpFields_q.memFormatValid && fpFields_q.memFormat == $past(firstByte[2:1]))
		else $error("Memory format wrong");
	pop_stack_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
		regFloatSeq |=> fpFields_q.popStack == $past(firstByte[1]))
		else $error("Pop bit wrong");
	pop_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
		memFloatSeq |=> !fpFields_q.popStack && !fpFields_q.destIsElement)
		else $error("Register form bits in memory form");
	dest_select_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
		regFloatSeq |=> fpFields_q.destIsElement == $past(firstByte[2])
			&& fpFields_q.reverseOrder == ($past(modRm[3]) ^ $past(firstByte[2])))
		else $error("Destination or order wrong");
	stack_element_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE15]
		instValid && isFloat |=> fpFields_q.stackElement == $past(modRm[2:0]))
		else $error("Stack element wrong");
	disp8_select_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
		instValid && modRm[7:6] == 2'h1 |=> addrFields_q.dispPresent && addrFields_q.dispBytesLog == 2'h0)
		else $error("Byte displacement wrong");
	disp32_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
		instValid && modRm[7:6] == 2'h0 && modRm[2:0] == 3'h5
			|=> !addrFields_q.baseValid && addrFields_q.dispPresent && addrFields_q.dispBytesLog == 2'h2)
		else $error("Bare displacement wrong");
	special_index_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE17]
		instValid && specialLegal |=> specialLegal_q && specialIndex_q == $past(modRm[5:3]))
		else $error("Legal special code not forwarded");
endmodule : opcode_field_decoder
`default_nettype wire

/* File: design/opcode_field_pkg.sv */
// Types shared by the instruction field decoder
`default_nettype none
package opcode_field_pkg;
	typedef enum logic [1:0] {
		MEM_REAL32 = 2'b00,
		MEM_INT32  = 2'b01,
		MEM_REAL64 = 2'b10,
		MEM_INT16  = 2'b11
	} mem_format_e;

	typedef enum logic [2:0] {
		COND_OVERFLOW   = 3'b000,
		COND_BELOW      = 3'b001,
		COND_ZERO       = 3'b010,
		COND_BELOW_EQ   = 3'b011,
		COND_SIGN       = 3'b100,
		COND_PARITY     = 3'b101,
		COND_LESS       = 3'b110,
		COND_LESS_EQ    = 3'b111
	} cond_e;

	typedef enum logic [1:0] {
		SEL_CONTROL = 2'b00,
		SEL_DEBUG   = 2'b01,
		SEL_TEST    = 2'b10,
		SEL_NONE    = 2'b11
	} special_e;

	// Raw instruction bytes from the fetch logic
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [7:0] sib;
	} inst_bytes_s;

	// Flag word that the condition test reads
	typedef struct packed {
		logic overflow;
		logic carry;
		logic zero;
		logic sign;
		logic parity;
	} flags_s;

	// Address generation fields
	typedef struct packed {
		logic       sibPresent;
		logic [3:0] scaleFactor;
		logic       indexValid;
		logic [2:0] indexReg;
		logic       baseValid;
		logic [2:0] baseReg;
		logic [1:0] dispBytesLog;
		logic       dispPresent;
		logic       registerOperand;
	} addr_fields_s;

	// Floating point fields
	typedef struct packed {
		logic        isFloat;
		logic [2:0]  minLength;
		mem_format_e memFormat;
		logic        memFormatValid;
		logic [2:0]  opcodePartA;
		logic [2:0]  opcodePartB;
		logic        popStack;
		logic        destIsElement;
		logic        reverseOrder;
		logic [2:0]  stackElement;
	} fp_fields_s;
endpackage : opcode_field_pkg
`default_nettype wire

/* File: design/sib_field_decode.sv */
// Scale-index-base and mod r/m address field decoder
`include "opcode_field_cfg.svh"
`default_nettype none
module sib_field_decode (
	// Mod r/m and index byte
	input  wire logic [7:0]                   modRm,
	input  wire logic [7:0]                   sib,
	// Decoded address fields
	output opcode_field_pkg::addr_fields_s    fields
);
	logic [1:0] modBits;
	logic [2:0] rmBits;
	logic [1:0] scaleBits;
	logic [2:0] indexBits;
	logic [2:0] baseBits;

	assign modBits   = modRm[7:6];
	assign rmBits    = modRm[2:0];
	assign scaleBits = sib[7:6];
	assign indexBits = sib[5:3];
	assign baseBits  = sib[2:0];

	always_comb begin
		fields = '0;
		fields.registerOperand = (modBits == `MOD_REGISTER);
		fields.sibPresent = (modBits != `MOD_REGISTER) && (rmBits == `RM_SIB_PRESENT);
		fields.scaleFactor = 4'(4'h1 << scaleBits); // [RULE1]
		// Code 100 drops the index term entirely [RULE2]
		fields.indexValid = fields.sibPresent && (indexBits != `SIB_NO_INDEX);
		fields.indexReg = indexBits;
		fields.baseReg = fields.sibPresent ? baseBits : rmBits;
		fields.baseValid = !fields.registerOperand;
		case (modBits)
			`MOD_NO_DISP: begin
				// No base register, bare 32-bit displacement
				if ((fields.sibPresent && baseBits == `BASE_DISP32_ONLY) ||
					(!fields.sibPresent && rmBits == `RM_DISP32_ONLY)) begin
					fields.baseValid = 1'b0;
					fields.dispPresent = 1'b1;
					fields.dispBytesLog = 2'h2;
				end
			end
			`MOD_DISP8: begin
				fields.dispPresent = 1'b1;
				fields.dispBytesLog = 2'h0;
			end
			`MOD_DISP32: begin
				fields.dispPresent = 1'b1;
				fields.dispBytesLog = 2'h2;
			end
			default: begin
				fields.dispPresent = 1'b0;
			end
		endcase
	end
endmodule : sib_field_decode
`default_nettype wire

/* File: design/special_reg_decode.sv */
// Control, debug and test register select decoder
`include "opcode_field_cfg.svh"
`default_nettype none
module special_reg_decode (
	// Select
	input  wire logic [1:0] regClass,
	input  wire logic [2:0] regCode,
	// Result
	output logic            legal,
	output logic [2:0]      regIndex
);
	always_comb begin
		legal = 1'b0;
		regIndex = 3'h0;
		case (regClass)
			`SPECIAL_CONTROL: begin
				legal = (regCode == 3'h0) || (regCode == 3'h2) || (regCode == 3'h3); // [RULE8]
			end
			`SPECIAL_DEBUG: begin
				legal = (regCode[2] == 1'b0) || (regCode[2:1] == 2'h3); // [RULE9]
			end
			`SPECIAL_TEST: begin
				legal = (regCode >= `TEST_LOWEST_CODE); // [RULE10]
			end
			default: begin
				legal = 1'b0;
			end
		endcase
		// Prohibited codes never reach the register file [RULE17]
		if (legal) begin
			regIndex = regCode;
		end
	end
endmodule : special_reg_decode
`default_nettype wire

/* File: tb/opcode_field_decoder_test.sv */
// Self-checking bench for the instruction field decoder
`default_nettype none
module opcode_field_decoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                           clk, rst_n, instValid, immIsByte, destWide32;
	logic [1:0]                     specialClass;
	logic [31:0]                    immRaw, immValue_q;
	opcode_field_pkg::inst_bytes_s  instBytes;
	opcode_field_pkg::flags_s       flags;
	logic                           decValid_q, undefinedAddr_q, srcIsRm_q, dstIsRm_q;
	logic                           condNegate_q, condTaken_q, specialLegal_q, illegalInst_q;
	logic [2:0]                     srcReg_q, specialIndex_q;
	opcode_field_pkg::addr_fields_s addrFields_q;
	opcode_field_pkg::cond_e        condSel_q;
	opcode_field_pkg::fp_fields_s   fpFields_q;
	int                             num_errors, check_count, cycles, seedDummy;

	opcode_field_decoder u_opcode_field_decoder (
		.clk(clk), .rst_n(rst_n), .instValid(instValid), .instBytes(instBytes),
		.immIsByte(immIsByte), .immRaw(immRaw), .destWide32(destWide32),
		.specialClass(specialClass), .flags(flags), .decValid_q(decValid_q),
		.addrFields_q(addrFields_q), .undefinedAddr_q(undefinedAddr_q), .srcReg_q(srcReg_q),
		.srcIsRm_q(srcIsRm_q), .dstIsRm_q(dstIsRm_q), .immValue_q(immValue_q),
		.condSel_q(condSel_q), .condNegate_q(condNegate_q), .condTaken_q(condTaken_q),
		.specialLegal_q(specialLegal_q), .specialIndex_q(specialIndex_q),
		.illegalInst_q(illegalInst_q), .fpFields_q(fpFields_q)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			results();
		end
	end

	task automatic results;
		$display("Errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : results

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	function automatic logic condOk(input logic [3:0] t, input opcode_field_pkg::flags_s f);
		logic r;
		case (t[3:1])
			3'h0: r = f.overflow;
			3'h1: r = f.carry;
			3'h2: r = f.zero;
			3'h3: r = f.carry | f.zero;
			3'h4: r = f.sign;
			3'h5: r = f.parity;
			3'h6: r = f.sign ^ f.overflow;
			default: r = f.zero | (f.sign ^ f.overflow);
		endcase
		return r ^ t[0];
	endfunction : condOk

	// Drives one instruction after a falling edge, checks it at the next falling edge
	task automatic apply(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
			input logic [1:0] cls);
		logic [1:0]  md;
		logic [2:0]  rm, ix, cd;
		logic        sp, lg, dp;
		logic [31:0] ie;
		md = b1[7:6];
		rm = b1[2:0];
		ix = b2[5:3];
		cd = b1[5:3];
		instValid = 1'b1;
		instBytes = {b0, b1, b2};
		specialClass = cls;
		immRaw = $urandom;
		immIsByte = 1'($urandom);
		destWide32 = 1'($urandom);
		flags = 5'($urandom);
		@(negedge clk);
		check(decValid_q, 1'b1);
		sp = md != 2'h3 && rm == 3'h4;
		check(addrFields_q.registerOperand, md == 2'h3);
		check(addrFields_q.sibPresent, sp);
		check(addrFields_q.baseReg, sp ? b2[2:0] : rm);
		if (sp) begin
			check(addrFields_q.scaleFactor, 4'h1 << b2[7:6]);
			check(addrFields_q.indexValid, ix != 3'h4);
			if (ix != 3'h4) check(addrFields_q.indexReg, ix);
			check(undefinedAddr_q, ix == 3'h4 && b2[7:6] != 2'h0);
		end
		if (md != 2'h3) begin
			dp = md != 2'h0 || (!sp && rm == 3'h5) || (sp && b2[2:0] == 3'h5);
			check(addrFields_q.dispPresent, dp);
			check(addrFields_q.baseValid, !(md == 2'h0 && dp));
			if (dp) check(addrFields_q.dispBytesLog, md == 2'h1 ? 2'h0 : 2'h2);
		end
		check(srcIsRm_q, b0[1]);
		check(dstIsRm_q, !b0[1]);
		check(srcReg_q, b0[1] ? b1[2:0] : b1[5:3]);
		if (immIsByte) begin
			if (!b0[1]) ie = {24'h000000, immRaw[7:0]};
			else if (destWide32) ie = {{24{immRaw[7]}}, immRaw[7:0]};
			else ie = {16'h0000, {8{immRaw[7]}}, immRaw[7:0]};
			check(immValue_q, ie);
		end else check(immValue_q, immRaw);
		check(condSel_q, b0[3:1]);
		check(condNegate_q, b0[0]);
		check(condTaken_q, condOk(b0[3:0], flags));
		case (cls)
			2'h0: lg = cd == 3'h0 || cd == 3'h2 || cd == 3'h3;
			2'h1: lg = cd < 3'h4 || cd > 3'h5;
			2'h2: lg = cd >= 3'h3;
			default: lg = 1'b0;
		endcase
		check(specialLegal_q, lg);
		check(specialIndex_q, lg ? cd : 3'h0);
		check(illegalInst_q, cls != 2'h3 && !lg);
		check(fpFields_q.isFloat, b0[7:3] == 5'h1B);
		check(fpFields_q.minLength, b0[7:3] == 5'h1B ? 3'h2 : 3'h1);
		check(fpFields_q.opcodePartA, b0[2:0]);
		check(fpFields_q.opcodePartB, b1[5:3]);
		if (b0[7:3] == 5'h1B && md == 2'h3) begin
			check(fpFields_q.popStack, b0[1]);
			check(fpFields_q.destIsElement, b0[2]);
			check(fpFields_q.reverseOrder, b1[3] ^ b0[2]);
			check(fpFields_q.stackElement, b1[2:0]);
		end else if (b0[7:3] == 5'h1B) begin
			check(fpFields_q.memFormatValid, 1'b1);
			check(fpFields_q.memFormat, b0[2:1]);
		end
	endtask : apply

	initial begin
		logic [2:0] held;
		seedDummy = $urandom(16902);
		rst_n = 1'b0;
		instValid = 1'b0;
		instBytes = '0;
		immIsByte = 1'b0;
		immRaw = 32'h0;
		destWide32 = 1'b0;
		specialClass = 2'h3;
		flags = '0;
		repeat (3) @(negedge clk);
		check({decValid_q, illegalInst_q, condTaken_q, specialLegal_q}, 4'h0);
		check(fpFields_q, '0);
		rst_n = 1'b1;
		// Every condition code, back to back
		for (int c = 0; c < 16; c++) apply({4'h7, 4'(c)}, 8'($urandom), 8'($urandom), 2'h3);
		// Every class and select code, prohibited ones included
		for (int k = 0; k < 32; k++) apply(8'($urandom), {2'h3, 3'(k), 3'($urandom)}, 8'($urandom), 2'(k >> 3));
		// Every scale and index pair with an index byte present
		for (int k = 0; k < 32; k++)
			apply(8'($urandom), {2'($urandom % 3), 3'($urandom), 3'h4}, {5'(k), 3'($urandom)}, 2'h3);
		// Floating point escapes in both register and memory forms
		for (int k = 0; k < 32; k++) apply({5'h1B, 3'(k)}, {k[4] ? 2'h3 : 2'(k), 6'($urandom)}, 8'($urandom), 2'h3);
		// Valid drops and condition select holds while no instruction is offered
		held = condSel_q;
		instValid = 1'b0;
		repeat (2) @(negedge clk);
		check(decValid_q, 1'b0);
		check(condSel_q, held);
		for (int k = 0; k < 200; k++) apply(8'($urandom), 8'($urandom), 8'($urandom), 2'($urandom));
		// Reset in mid-run clears at once, without a clock edge
		rst_n = 1'b0;
		#1;
		check({decValid_q, illegalInst_q}, 2'h0);
		@(negedge clk);
		rst_n = 1'b1;
		apply({5'h1B, 3'h6}, 8'hC9, 8'h00, 2'h1);
		results();
	end
endmodule : opcode_field_decoder_test
`default_nettype wire
